// ### hw/wfm_pkg.sv
// constants shared by the wake-up frame pattern match block
`default_nettype none

package wfm_pkg;

   // -------------------------------------------------------------
   // sizes
   // -------------------------------------------------------------
   localparam int WFM_PATTERNS  = 2;
   localparam int WFM_MASK_REGS = 4;
   localparam int WFM_REG_W     = 16;
   localparam int WFM_BANK_W    = 8;
   localparam int WFM_IDX_W     = 6;

   // -------------------------------------------------------------
   // register indices, byte address is four times the index
   // -------------------------------------------------------------
   localparam logic [5:0] WFM_IDX_CRC_LO   = 6'h00;
   localparam logic [5:0] WFM_IDX_CRC_HI   = 6'h02;
   localparam logic [5:0] WFM_IDX_MASK0    = 6'h04;
   localparam logic [5:0] WFM_IDX_MASK3    = 6'h0a;
   localparam logic [5:0] WFM_IDX_BANK_SEL = 6'h0e;
   localparam logic [5:0] WFM_IDX_IRQ_STAT = 6'h10;
   localparam logic [5:0] WFM_IDX_IRQ_CLR  = 6'h11;
   localparam logic [5:0] WFM_IDX_IRQ_EN   = 6'h12;

   // -------------------------------------------------------------
   // banks and reset values
   // -------------------------------------------------------------
   localparam logic [7:0]  WFM_BANK_PAT2 = 8'h06;
   localparam logic [7:0]  WFM_BANK_PAT3 = 8'h07;
   localparam logic [7:0]  WFM_BANK_RST  = 8'h00;
   localparam logic [15:0] WFM_REG_RST   = 16'h0000;
   localparam logic [31:0] WFM_CRC_RST   = 32'h0000_0000;
   localparam logic [1:0]  WFM_FLAG_RST  = 2'h0;

   // -------------------------------------------------------------
   // Ethernet CRC, reflected form
   // -------------------------------------------------------------
   localparam logic [31:0] WFM_CRC_INIT = 32'hffff_ffff;
   localparam logic [31:0] WFM_CRC_POLY = 32'hedb8_8320;

endpackage

`default_nettype wire

// ### hw/wfm_crc_lane.sv
// masked-byte CRC engine for one wake-up pattern
`timescale 1ns/1ns
`default_nettype none

module wfm_crc_lane
   import wfm_pkg::*;
#(
   parameter int MASK_BYTES = 64
)
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  byte_valid,
   input  wire logic                  byte_first,
   input  wire logic                  byte_last,
   input  wire logic [7:0]            byte_data,
   input  wire logic [MASK_BYTES-1:0] byte_mask,
   input  wire logic [31:0]           expected_crc,
   output logic                       frame_match
);

   localparam int POS_W = $clog2(MASK_BYTES) + 1;

   if (MASK_BYTES < 16 || (MASK_BYTES % 16) != 0) begin : g_chk
      $error("wfm_crc_lane: MASK_BYTES must be a multiple of 16");
   end

   typedef struct packed {
      logic [POS_W-1:0] pos;
      logic [31:0]      crc;
      logic             match;
   } wfm_lane_state_t;

   wfm_lane_state_t cur;
   wfm_lane_state_t next_cur;

   // -------------------------------------------------------------
   // one byte through the reflected CRC, lsb first as on the wire
   // -------------------------------------------------------------
   function automatic logic [31:0] crc_byte(input logic [31:0] c_in,
                                            input logic [7:0]  d);
      logic [31:0] c;
      c = c_in;
      for (int i = 0; i < 8; i++) begin
         c = (c >> 1) ^ ((c[0] ^ d[i]) ? WFM_CRC_POLY : 32'h0000_0000);
      end
      return c;
   endfunction

   logic [POS_W-1:0] idx;
   logic             in_range;
   logic             sel;
   logic [31:0]      base;
   logic [31:0]      crc_new;

   always_comb begin
      next_cur       = cur;
      next_cur.match = 1'b0;
      idx      = byte_first ? '0 : cur.pos;
      base     = byte_first ? WFM_CRC_INIT : cur.crc;
      in_range = (idx < POS_W'(MASK_BYTES));
      // bytes past the mask window never enter the CRC
      sel      = in_range && byte_mask[idx[POS_W-2:0]];
      crc_new  = sel ? crc_byte(base, byte_data) : base;
      if (byte_valid) begin
         next_cur.crc = crc_new;
         next_cur.pos = in_range ? idx + POS_W'(1) : idx;
         if (byte_last) begin
            // an empty mask would match every frame, so it never matches
            next_cur.match = (|byte_mask) && (~crc_new == expected_crc);
            next_cur.crc   = WFM_CRC_INIT;
            next_cur.pos   = '0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cur.pos   <= '0;
         cur.crc   <= WFM_CRC_INIT;
         cur.match <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   assign frame_match = cur.match;

endmodule

`default_nettype wire

// ### hw/wfm_match_top.sv
// wake-up frame pattern match block with AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none

module wfm_match_top
   import wfm_pkg::*;
#(
   parameter int MASK_BYTES = 64
)
(
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   // AHB-Lite slave
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic                         hreadyout,
   output logic                         hresp,
   output logic [31:0]                  hrdata,
   // received frame bytes from the MAC, same clock
   input  wire logic                    rx_byte_valid,
   input  wire logic [7:0]              rx_byte_data,
   input  wire logic                    rx_frame_first,
   input  wire logic                    rx_frame_last,
   // results
   output logic [WFM_PATTERNS-1:0]      wake_match,
   output logic                         irq
);

   // -------------------------------------------------------------
   // elaboration checks
   // -------------------------------------------------------------
   if (MASK_BYTES != WFM_MASK_REGS * WFM_REG_W) begin : g_chk
      $error("wfm_match_top: MASK_BYTES must equal the mask register bits");
   end

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef struct packed {
      logic [WFM_BANK_W-1:0]                                 bank;
      logic [WFM_PATTERNS-1:0][31:0]                         exp_crc;
      logic [WFM_PATTERNS-1:0][WFM_MASK_REGS-1:0][WFM_REG_W-1:0] mask;
      logic [WFM_PATTERNS-1:0]                               stat;
      logic [WFM_PATTERNS-1:0]                               en;
      logic                                                  wr_pend;
      logic [WFM_IDX_W-1:0]                                  wr_idx;
      logic [31:0]                                           rdata;
      logic                                                  rdy;
      logic                                                  resp;
      logic [WFM_PATTERNS-1:0]                               match;
      logic                                                  irq;
   } wfm_top_state_t;

   wfm_top_state_t cur;
   wfm_top_state_t next_cur;

   logic [WFM_PATTERNS-1:0] lane_match;

   // -------------------------------------------------------------
   // decoders
   // -------------------------------------------------------------
   // bit 1: bank holds a pattern, bit 0: which pattern
   function automatic logic [1:0] bank_decode(input logic [WFM_BANK_W-1:0] b);
      logic [1:0] r;
      r = 2'b00;
      if (b == WFM_BANK_PAT2) begin
         r = 2'b10;
      end else if (b == WFM_BANK_PAT3) begin
         r = 2'b11;
      end
      return r;
   endfunction

   // bit 2: index is a mask register, bits 1:0: which of the four
   function automatic logic [2:0] mask_decode(input logic [WFM_IDX_W-1:0] i);
      logic [WFM_IDX_W-1:0] d;
      logic [2:0]           r;
      d = i - WFM_IDX_MASK0;
      r = 3'b000;
      // masks sit on even indices from 0x04 up to 0x0a
      if (i >= WFM_IDX_MASK0 && i <= WFM_IDX_MASK3 && !i[0]) begin
         r = {1'b1, d[2:1]};
      end
      return r;
   endfunction

   function automatic logic [31:0] reg_read(input wfm_top_state_t s,
                                            input logic [WFM_IDX_W-1:0] i);
      logic [1:0]  bd;
      logic [2:0]  md;
      logic [31:0] r;
      bd = bank_decode(s.bank);
      md = mask_decode(i);
      r  = 32'h0000_0000;
      if (i == WFM_IDX_BANK_SEL) begin
         r[WFM_BANK_W-1:0] = s.bank;
      end else if (i == WFM_IDX_IRQ_STAT) begin
         r[WFM_PATTERNS-1:0] = s.stat;
      end else if (i == WFM_IDX_IRQ_EN) begin
         r[WFM_PATTERNS-1:0] = s.en;
      end else if (bd[1]) begin
         if (i == WFM_IDX_CRC_LO) begin
            r[15:0] = s.exp_crc[bd[0]][15:0];
         end else if (i == WFM_IDX_CRC_HI) begin
            r[15:0] = s.exp_crc[bd[0]][31:16];
         end else if (md[2]) begin
            r[15:0] = s.mask[bd[0]][md[1:0]];
         end
      end
      return r;
   endfunction

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   logic                    take;
   logic [1:0]              wr_bank;
   logic [2:0]              wr_mask;
   logic [WFM_PATTERNS-1:0] clr;

   always_comb begin
      next_cur = cur;
      take     = hsel && htrans[1] && hready;
      wr_bank  = bank_decode(cur.bank);
      wr_mask  = mask_decode(cur.wr_idx);
      clr      = '0;

      // data phase of a write taken on the previous edge
      if (cur.wr_pend) begin
         if (cur.wr_idx == WFM_IDX_BANK_SEL) begin
            // reachable in any bank so software can always leave one
            next_cur.bank = hwdata[WFM_BANK_W-1:0];
         end else if (cur.wr_idx == WFM_IDX_IRQ_CLR) begin
            clr = hwdata[WFM_PATTERNS-1:0];
         end else if (cur.wr_idx == WFM_IDX_IRQ_EN) begin
            next_cur.en = hwdata[WFM_PATTERNS-1:0];
         end else if (wr_bank[1]) begin
            if (cur.wr_idx == WFM_IDX_CRC_LO) begin
               next_cur.exp_crc[wr_bank[0]][15:0] = hwdata[15:0];
            end else if (cur.wr_idx == WFM_IDX_CRC_HI) begin
               next_cur.exp_crc[wr_bank[0]][31:16] = hwdata[15:0];
            end else if (wr_mask[2]) begin
               next_cur.mask[wr_bank[0]][wr_mask[1:0]] = hwdata[15:0];
            end
         end
      end

      // a match in the same cycle as its clear stays set
      next_cur.stat  = (cur.stat & ~clr) | lane_match;
      next_cur.match = lane_match;
      next_cur.irq   = |(next_cur.stat & next_cur.en);

      // address phase; zero wait states, always OKAY
      next_cur.rdy     = 1'b1;
      next_cur.resp    = 1'b0;
      next_cur.wr_pend = take && hwrite;
      next_cur.wr_idx  = haddr[WFM_IDX_W+1:2];
      // read from the post-write view so a write then read sees new data
      next_cur.rdata   = (take && !hwrite) ? reg_read(next_cur, haddr[WFM_IDX_W+1:2])
                                           : 32'h0000_0000;
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cur.bank    <= WFM_BANK_RST;
         cur.exp_crc <= {WFM_PATTERNS{WFM_CRC_RST}};
         cur.mask    <= {(WFM_PATTERNS * WFM_MASK_REGS){WFM_REG_RST}};
         cur.stat    <= WFM_FLAG_RST;
         cur.en      <= WFM_FLAG_RST;
         cur.wr_pend <= 1'b0;
         cur.wr_idx  <= '0;
         cur.rdata   <= 32'h0000_0000;
         cur.rdy     <= 1'b1;
         cur.resp    <= 1'b0;
         cur.match   <= WFM_FLAG_RST;
         cur.irq     <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   // -------------------------------------------------------------
   // one CRC engine per pattern
   // -------------------------------------------------------------
   for (genvar g = 0; g < WFM_PATTERNS; g++) begin : g_lane
      wfm_crc_lane #(
         .MASK_BYTES (MASK_BYTES)
      ) u_lane (
         .clk_sys      (clk_sys),
         .rst          (rst),
         .byte_valid   (rx_byte_valid),
         .byte_first   (rx_frame_first),
         .byte_last    (rx_frame_last),
         .byte_data    (rx_byte_data),
         .byte_mask    (cur.mask[g]),
         .expected_crc (cur.exp_crc[g]),
         .frame_match  (lane_match[g])
      );
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign hreadyout  = cur.rdy;
   assign hresp      = cur.resp;
   assign hrdata     = cur.rdata;
   assign wake_match = cur.match;
   assign irq        = cur.irq;

endmodule

`default_nettype wire

// ### tb/wfm_match_top_properties.sv
// port assertions for the wake-up pattern match block
`timescale 1ns/1ns
`default_nettype none
module wfm_match_checker
   import wfm_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        rx_byte_valid,
   input wire logic        rx_frame_last,
   input wire logic [1:0]  wake_match,
   input wire logic        irq
);
   wire logic taken = hsel & htrans[1] & hready;
   wire logic en_wr = taken & hwrite & (haddr[7:2] == WFM_IDX_IRQ_EN);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // sequences
   // ------------------------------------------------------------
   sequence clr_all;
      taken && hwrite && haddr[7:2] == WFM_IDX_IRQ_CLR ##1 hwdata[1:0] == 2'b11;
   endsequence
   sequence last_byte;
      rx_byte_valid && rx_frame_last;
   endsequence
   a_ready_high: assert property (hreadyout) else $error("ready low");
   a_resp_okay: assert property (!hresp) else $error("error response");
   a_rdata_cause: assert property (hrdata != 32'h0000_0000 |-> $past(taken && !hwrite))
      else $error("read data without read");
   a_rdata_write: assert property (taken && hwrite |=> hrdata == 32'h0000_0000)
      else $error("read data after write");
   a_match_last: assert property (wake_match != 2'b00 |->
      $past(rx_byte_valid && rx_frame_last, 2)) else $error("match without frame end");
   a_reset_quiet: assert property ($fell(rst) |-> wake_match == 2'b00 && !irq)
      else $error("outputs busy after reset");
   a_irq_clear: assert property (clr_all |=> !irq || wake_match != 2'b00)
      else $error("irq held after clear");
   a_irq_rise: assert property ($rose(irq) |-> wake_match != 2'b00 || $past(en_wr, 2))
      else $error("irq without cause");
   c_frame_end: cover property (last_byte ##2 wake_match != 2'b00);
endmodule
bind wfm_match_top wfm_match_checker CHK (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hreadyout, .hresp, .hrdata, .rx_byte_valid, .rx_frame_last,
   .wake_match, .irq);
`default_nettype wire

// ### tb/wfm_station_model.sv
// remote station model feeding received frame bytes
`timescale 1ns/1ns
`default_nettype none
module wfm_station_model (
   input  wire logic  clk_sys,
   output logic       rx_byte_valid,
   output logic [7:0] rx_byte_data,
   output logic       rx_frame_first,
   output logic       rx_frame_last
);
   logic [7:0] fr [0:127];
   initial begin
      rx_byte_valid = 1'b0;
      rx_byte_data = 8'h00;
      rx_frame_first = 1'b0;
      rx_frame_last = 1'b0;
   end
   // call just after a rising edge; gap idles the line between bytes
   task automatic send_frame(input int len, input int gap);
      for (int i = 0; i < len; i++) begin
         rx_byte_valid <= 1'b1;
         rx_byte_data <= fr[i];
         rx_frame_first <= (i == 0);
         rx_frame_last <= (i == len - 1);
         @(posedge clk_sys);
         if (i == len - 1 || gap > 0) begin
            rx_byte_valid <= 1'b0;
            // idle data never repeats the last byte
            rx_byte_data <= ~fr[i];
            // frame markers drop while idle so none lingers unqualified
            rx_frame_first <= 1'b0;
            rx_frame_last <= 1'b0;
            if (i < len - 1) repeat (gap) @(posedge clk_sys);
         end
      end
   endtask
endmodule
`default_nettype wire

// ### tb/wfm_match_top_test.sv
// self-checking bench for the wake-up pattern match block
`timescale 1ns/1ns
`default_nettype none
module wfm_match_top_test
   import wfm_pkg::*;
;
   logic        clk_sys, rst, hsel, hwrite, hreadyout, hresp, irq;
   logic        rx_byte_valid, rx_frame_first, rx_frame_last;
   logic [1:0]  htrans, wake_match;
   logic [2:0]  hsize;
   logic [7:0]  rx_byte_data;
   logic [31:0] haddr, hwdata, hrdata;
   wire logic   hready;
   int          bad_count = 0;
   int          n_compared = 0;
   assign hready = hreadyout;
   wfm_match_top #(.MASK_BYTES(64)) DUT (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .rx_byte_valid, .rx_byte_data,
      .rx_frame_first, .rx_frame_last, .wake_match, .irq);
   wfm_station_model STN (.clk_sys, .rx_byte_valid, .rx_byte_data, .rx_frame_first,
      .rx_frame_last);
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, i, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [5:0] i, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, i, d, x);
   endtask
   task automatic rc(input logic [5:0] i, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, i, 32'h0000_0000, x);
      chk(x, e);
   endtask
   // upper halves are written as ones and must read back as zero
   task automatic regs(input logic w, input logic [7:0] b, input logic [31:0] c,
                       input logic [63:0] m);
      wr(WFM_IDX_BANK_SEL, {24'h00_0000, b});
      if (w) begin
         wr(WFM_IDX_CRC_LO, {16'hffff, c[15:0]});
         wr(WFM_IDX_CRC_HI, {16'hffff, c[31:16]});
         for (int k = 0; k < 4; k++) wr(WFM_IDX_MASK0 + 6'(2 * k), {16'hffff, m[16*k +: 16]});
      end else begin
         rc(WFM_IDX_CRC_LO, {16'h0000, c[15:0]});
         rc(WFM_IDX_CRC_HI, {16'h0000, c[31:16]});
         for (int k = 0; k < 4; k++) begin
            rc(WFM_IDX_MASK0 + 6'(2 * k), {16'h0000, m[16*k +: 16]});
         end
      end
   endtask
   function automatic logic [31:0] crc_of(input int len, input logic [63:0] m);
      logic [31:0] c;
      c = WFM_CRC_INIT;
      for (int i = 0; i < len && i < 64; i++) begin
         if (m[i]) begin
            c = c ^ {24'h00_0000, STN.fr[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ WFM_CRC_POLY : c >> 1;
         end
      end
      return ~c;
   endfunction
   task automatic frame(input int len, input int gap, input logic [1:0] ew);
      logic [1:0] w;
      w = 2'b00;
      STN.send_frame(len, gap);
      repeat (6) begin
         @(posedge clk_sys);
         w = w | wake_match;
      end
      chk({30'h0000_0000, w}, {30'h0000_0000, ew});
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rc(WFM_IDX_BANK_SEL, 32'h0000_0000);
      regs(1'b0, WFM_BANK_PAT2, 32'h0000_0000, 64'h0);
      regs(1'b0, WFM_BANK_PAT3, 32'h0000_0000, 64'h0);
      // zero mask leaves the start value, whose inverse equals the zero expectation
      for (int i = 0; i < 70; i++) STN.fr[i] = 8'(i * 37 + 5);
      frame(70, 0, 2'b00);
      $display("test reset values done");
   endtask
   task automatic t_regs();
      regs(1'b1, WFM_BANK_PAT2, 32'hc0de_1234, 64'h8001_4002_2004_1008);
      regs(1'b1, WFM_BANK_PAT3, 32'h5a5a_0ff0, 64'h0102_0408_1020_4080);
      regs(1'b0, WFM_BANK_PAT2, 32'hc0de_1234, 64'h8001_4002_2004_1008);
      regs(1'b0, WFM_BANK_PAT3, 32'h5a5a_0ff0, 64'h0102_0408_1020_4080);
      wr(WFM_IDX_BANK_SEL, 32'h0000_0003);
      rc(WFM_IDX_CRC_LO, 32'h0000_0000);
      rc(WFM_IDX_BANK_SEL, 32'h0000_0003);
      rc(6'h3f, 32'h0000_0000);
      $display("test register banks done");
   endtask
   task automatic t_match();
      logic [63:0] m2, m3;
      m2 = 64'h8001_8001_8001_8001;
      m3 = 64'h0000_0000_0000_00f0;
      for (int i = 0; i < 70; i++) STN.fr[i] = 8'(i * 37 + 5);
      regs(1'b1, WFM_BANK_PAT2, crc_of(70, m2), m2);
      regs(1'b1, WFM_BANK_PAT3, crc_of(70, m3), m3);
      wr(WFM_IDX_IRQ_EN, 32'h0000_0001);
      rc(WFM_IDX_IRQ_EN, 32'h0000_0001);
      rc(WFM_IDX_IRQ_CLR, 32'h0000_0000);
      frame(70, 0, 2'b11);
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      rc(WFM_IDX_IRQ_STAT, 32'h0000_0003);
      wr(WFM_IDX_IRQ_CLR, 32'h0000_0001);
      @(posedge clk_sys);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      rc(WFM_IDX_IRQ_STAT, 32'h0000_0002);
      STN.fr[20] = ~STN.fr[20];
      frame(70, 2, 2'b11);
      STN.fr[63] = ~STN.fr[63];
      frame(70, 1, 2'b10);
      STN.fr[63] = ~STN.fr[63];
      STN.fr[0] = ~STN.fr[0];
      frame(70, 0, 2'b10);
      wr(WFM_IDX_IRQ_CLR, 32'h0000_0003);
      @(posedge clk_sys);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      $display("test frame matching done");
   endtask
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      end_sim();
   end
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_reset();
      t_regs();
      t_match();
      end_sim();
   end
endmodule
`default_nettype wire
